// ==== core/sirq_map.svh ====
/*
  constants for the serial-module interrupt, return and wake-up logic:
  protocol mode codes, instruction timing counts and the vector default.
  assumes it is included by bare name from the package and the top module.
*/
`ifndef SIRQ_MAP_SVH
`define SIRQ_MAP_SVH

// protocol mode codes as driven by the serial module
`define SIRQ_MODE_SPI 2'h0
`define SIRQ_MODE_I2C 2'h1
`define SIRQ_MODE_UART 2'h2

// instruction timing: one instruction cycle is four system clocks
`define SIRQ_CLKS_PER_INSTR 4
// returns and vector calls take two instruction cycles
`define SIRQ_BRANCH_INSTRS 2
// cycles a branch holds the sequencer, minus one for the count load
`define SIRQ_BRANCH_LOAD 4'((`SIRQ_CLKS_PER_INSTR * `SIRQ_BRANCH_INSTRS) - 1)

// reset values
`define SIRQ_FLAG_RST 1'h0
`define SIRQ_GIE_RST 1'h0
`define SIRQ_CNT_RST 4'h0
`define SIRQ_MODE_RST 2'h0

// default vector address, width of the program counter
`define SIRQ_PC_W 12
`define SIRQ_VECTOR_DEF 12'h010

`endif

// ==== core/sirq_pkg.sv ====
/*
  types for the serial-module interrupt logic: mode and sequencer enums
  and the packed state of the top module.
  assumes sirq_map.svh is on the include path.
*/
`include "sirq_map.svh"

package sirq_pkg;

  // protocol mode selected in the serial module
  typedef enum logic [1:0] {
    SIRQ_SPI = `SIRQ_MODE_SPI,
    SIRQ_I2C = `SIRQ_MODE_I2C,
    SIRQ_UART = `SIRQ_MODE_UART,
    SIRQ_MODE_RSVD = 2'h3
  } sirq_mode_e;

  // sequencer: idle, vector entry, return in progress
  typedef enum logic [1:0] {
    SIRQ_IDLE = 2'b00,
    SIRQ_ENTRY = 2'b01,
    SIRQ_RETURN = 2'b10
  } sirq_seq_e;

  // whole state of the top module
  typedef struct packed {
    sirq_seq_e seq;
    logic [3:0] cnt;
    logic req_flag;
    logic gie;
    logic in_service;
    logic ret_is_return_from_interrupt;
    logic vector_call;
    logic core_busy;
    logic pc_pop;
    logic [1:0] src_mode;
    logic [`SIRQ_PC_W-1:0] vector_addr;
  } sirq_state_s;

endpackage

// ==== core/sirq_wake_detect.sv ====
/*
  rising-edge detector over a vector of interrupt request flags; gives a
  one-cycle registered wake pulse while the device is in a low-power mode.
  assumes the flags come from logic on the same clock.
*/
`timescale 1ns/100ps

module sirq_wake_detect #(
  parameter int W = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // flags and power state
  input wire logic [W-1:0] flags,
  input wire logic low_power,
  // registered wake pulse
  output logic wake
);

  typedef struct packed {
    logic [W-1:0] prev;
    logic wake;
  } sirq_wd_state_s;

  sirq_wd_state_s st_reg;
  sirq_wd_state_s st_next;
  logic [W-1:0] rise;

  // per-flag low-to-high detect; enables are not looked at
  genvar gi;
  generate
    for (gi = 0; gi < W; gi++) begin : g_rise
      assign rise[gi] = flags[gi] & ~st_reg.prev[gi];
    end
  endgenerate

  // a flag already high before sleep never rises, so it cannot wake
  always_comb begin
    st_next = st_reg;
    st_next.prev = flags;
    st_next.wake = low_power & (|rise);
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign wake = st_reg.wake;

endmodule

// ==== core/sirq_top.sv ====
/*
  serial-module interrupt request, vectoring, return and wake-up logic.
  holds the shared request flag and the global enable, tells the core
  sequencer when to call the vector and times both return instructions.
  assumes every input comes from logic on clk: the serial module engines,
  the core sequencer and the software write decode.
*/
`timescale 1ns/100ps

`include "sirq_map.svh"

module sirq_top #(
  parameter logic [`SIRQ_PC_W-1:0] VECTOR_ADDR = `SIRQ_VECTOR_DEF,
  parameter int OTHER_W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // serial module mode
  input wire logic [1:0] mode,
  // spi and i2c events, one-cycle pulses
  input wire logic byte_done,
  input wire logic i2c_addr_match,
  input wire logic i2c_bus_timeout,
  // uart events, one-cycle pulses
  input wire logic uart_tx_empty,
  input wire logic uart_tx_idle,
  input wire logic uart_rx_avail,
  input wire logic uart_rx_overrun,
  input wire logic uart_addr_det,
  input wire logic uart_rx_wake,
  // software writes, one-cycle pulses
  input wire logic sw_flag_set,
  input wire logic sw_flag_clr,
  input wire logic sw_gie_set,
  input wire logic sw_gie_clr,
  // software enable level
  input wire logic serial_module_irq_en,
  // core sequencer
  input wire logic instr_boundary,
  input wire logic stack_full,
  input wire logic return_from_interrupt,
  input wire logic plain_return,
  // power state and the other sources' request flags
  input wire logic low_power,
  input wire logic [OTHER_W-1:0] other_req_flags,
  // flag and enable state
  output logic serial_module_req_flag,
  output logic global_irq_en,
  output logic in_service,
  output logic [1:0] src_mode,
  // to the core sequencer
  output logic vector_call,
  output logic [`SIRQ_PC_W-1:0] vector_addr,
  output logic core_busy,
  output logic pc_pop,
  // wake request
  output logic wake_up
);

  sirq_pkg::sirq_state_s st_reg;
  sirq_pkg::sirq_state_s st_next;
  sirq_pkg::sirq_mode_e mode_e;
  logic spi_i2c_evt;
  logic uart_evt;
  logic hw_set;
  logic take_irq;
  logic [OTHER_W:0] wake_flags;

  assign mode_e = sirq_pkg::sirq_mode_e'(mode);

  // event sources, gated by the selected protocol mode
  always_comb begin
    spi_i2c_evt = byte_done | i2c_addr_match | i2c_bus_timeout;
    uart_evt = uart_tx_empty | uart_tx_idle | uart_rx_avail |
               uart_rx_overrun | uart_addr_det | uart_rx_wake;
    unique case (mode_e)
      sirq_pkg::SIRQ_SPI: begin
        hw_set = spi_i2c_evt;
      end
      sirq_pkg::SIRQ_I2C: begin
        hw_set = spi_i2c_evt;
      end
      sirq_pkg::SIRQ_UART: begin
        hw_set = uart_evt;
      end
      default: begin
        // reserved mode code raises nothing
        hw_set = 1'b0;
      end
    endcase
  end

  // vector entry decision, taken only at an instruction boundary
  always_comb begin
    // low enable just holds the flag
    take_irq = (st_reg.seq == sirq_pkg::SIRQ_IDLE) & instr_boundary &
               st_reg.gie & serial_module_irq_en & st_reg.req_flag &
               ~stack_full;
  end

  // next state of flag, enable and sequencer
  always_comb begin
    st_next = st_reg;
    st_next.vector_call = 1'b0;
    st_next.pc_pop = 1'b0;

    // set regardless of enable; held until a software clear or a vector entry
    // set beats clear so an event in the clearing cycle is kept
    st_next.req_flag = (st_reg.req_flag & ~sw_flag_clr & ~take_irq) |
                       hw_set | sw_flag_set;

    // software access to the global enable
    if (sw_gie_set) begin
      st_next.gie = 1'b1;
    end else if (sw_gie_clr) begin
      st_next.gie = 1'b0;
    end

    unique case (st_reg.seq)
      sirq_pkg::SIRQ_IDLE: begin
        if (take_irq) begin
          // entry drops the global enable
          // entry wins over a software set in the same cycle
          st_next.gie = 1'b0;
          // call pushes the program counter only
          st_next.vector_call = 1'b1;
          st_next.in_service = 1'b1;
          // uart status left to the uart itself
          st_next.src_mode = mode;
          st_next.seq = sirq_pkg::SIRQ_ENTRY;
          st_next.cnt = `SIRQ_BRANCH_LOAD;
          st_next.core_busy = 1'b1;
        end else if (return_from_interrupt | plain_return) begin
          st_next.seq = sirq_pkg::SIRQ_RETURN;
          st_next.cnt = `SIRQ_BRANCH_LOAD;
          st_next.core_busy = 1'b1;
          st_next.ret_is_return_from_interrupt = return_from_interrupt;
        end
      end
      sirq_pkg::SIRQ_ENTRY: begin
        // the call itself occupies two instruction cycles
        if (st_reg.cnt == `SIRQ_CNT_RST) begin
          st_next.seq = sirq_pkg::SIRQ_IDLE;
          st_next.core_busy = 1'b0;
        end else begin
          st_next.cnt = st_reg.cnt - 4'h1;
        end
      end
      sirq_pkg::SIRQ_RETURN: begin
        if (st_reg.cnt == `SIRQ_CNT_RST) begin
          st_next.seq = sirq_pkg::SIRQ_IDLE;
          st_next.core_busy = 1'b0;
          st_next.pc_pop = 1'b1;
          st_next.in_service = 1'b0;
          if (st_reg.ret_is_return_from_interrupt) begin
            st_next.gie = 1'b1;
          end
          // plain return keeps the enable as it is
        end else begin
          st_next.cnt = st_reg.cnt - 4'h1;
        end
      end
      default: begin
        // unused code, recover to idle
        st_next.seq = sirq_pkg::SIRQ_IDLE;
        st_next.core_busy = 1'b0;
        st_next.cnt = `SIRQ_CNT_RST;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg.seq <= sirq_pkg::SIRQ_IDLE;
      st_reg.cnt <= `SIRQ_CNT_RST;
      st_reg.req_flag <= `SIRQ_FLAG_RST;
      st_reg.gie <= `SIRQ_GIE_RST;
      st_reg.in_service <= 1'b0;
      st_reg.ret_is_return_from_interrupt <= 1'b0;
      st_reg.vector_call <= 1'b0;
      st_reg.core_busy <= 1'b0;
      st_reg.pc_pop <= 1'b0;
      st_reg.src_mode <= `SIRQ_MODE_RST;
      st_reg.vector_addr <= VECTOR_ADDR;
    end else begin
      st_reg <= st_next;
    end
  end

  // wake detection over this flag and the other sources' flags
  // note: registered, so it needs clk running; an osc-stopped wake
  // must be built from these flags outside this clock domain
  assign wake_flags = {other_req_flags, st_reg.req_flag};

  // a flag set before sleep cannot rise
  sirq_wake_detect #(
    .W(OTHER_W + 1)
  ) u_wake (
    .clk(clk),
    .rst_n(rst_n),
    .flags(wake_flags),
    .low_power(low_power),
    .wake(wake_up)
  );

  // outputs straight from the state register
  assign serial_module_req_flag = st_reg.req_flag;
  assign global_irq_en = st_reg.gie;
  assign in_service = st_reg.in_service;
  assign src_mode = st_reg.src_mode;
  assign vector_call = st_reg.vector_call;
  assign vector_addr = st_reg.vector_addr;
  assign core_busy = st_reg.core_busy;
  assign pc_pop = st_reg.pc_pop;

endmodule

// ==== tb/sirq_checker.sv ====
/* concurrent checks on the serial irq top ports
   assumes one clock domain and the async active-low reset */
`timescale 1ns/100ps
module sirq_checker #(
  parameter int OTHER_W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // inputs of the top
  input wire logic [1:0] mode,
  input wire logic byte_done,
  input wire logic uart_rx_avail,
  input wire logic sw_flag_clr,
  input wire logic sw_gie_set,
  input wire logic serial_module_irq_en,
  input wire logic instr_boundary,
  input wire logic stack_full,
  input wire logic return_from_interrupt,
  input wire logic plain_return,
  input wire logic low_power,
  input wire logic [OTHER_W-1:0] other_req_flags,
  // outputs of the top
  input wire logic serial_module_req_flag,
  input wire logic global_irq_en,
  input wire logic vector_call,
  input wire logic core_busy,
  input wire logic pc_pop,
  input wire logic wake_up
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // call only when every gate was open
  property p_gate;
    $rose(vector_call) |-> $past(global_irq_en & serial_module_irq_en &
      serial_module_req_flag & !stack_full & instr_boundary);
  endproperty
  a_gate: assert property (p_gate) else $error("vector call without open gates");
  // entry drops the global enable
  property p_clr;
    vector_call |-> !global_irq_en && core_busy;
  endproperty
  a_clr: assert property (p_clr) else $error("enable still set at entry");
  // busy spans exactly two instruction cycles
  property p_busy;
    $rose(core_busy) |-> core_busy [*8] ##1 !core_busy;
  endproperty
  a_busy: assert property (p_busy) else $error("busy length wrong");
  // entry blocked by the full stack, so the return is taken
  property p_return_from_interrupt;
    return_from_interrupt && !core_busy && stack_full |-> ##9 (pc_pop && global_irq_en);
  endproperty
  a_return_from_interrupt: assert property (p_return_from_interrupt) else $error("return from interrupt wrong");
  // plain return leaves the enable low
  property p_ret;
    plain_return && !core_busy && !global_irq_en && !sw_gie_set ##1 !sw_gie_set [*8]
      |=> pc_pop && !global_irq_en;
  endproperty
  a_ret: assert property (p_ret) else $error("plain return wrong");
  // pending flag held while the enable is low
  property p_hold;
    serial_module_req_flag && !sw_flag_clr && !global_irq_en |=> serial_module_req_flag;
  endproperty
  a_hold: assert property (p_hold) else $error("pending flag lost");
  // events of the selected mode set the flag
  property p_set;
    (mode < 2'h2 && byte_done) || (mode == 2'h2 && uart_rx_avail) |=> serial_module_req_flag;
  endproperty
  a_set: assert property (p_set) else $error("event did not set flag");
  // a rising flag of the first other source wakes in low power, enables aside
  property p_wake;
    $rose(other_req_flags[0]) && low_power |=> wake_up;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on rising flag");
  c_call: cover property (vector_call);
  c_return_from_interrupt: cover property (pc_pop && global_irq_en);
  c_wake: cover property (wake_up);
endmodule

bind sirq_top sirq_checker #(.OTHER_W(OTHER_W)) u_chk (.*);

// ==== tb/sirq_core_model.sv ====
/* core sequencer model: instruction boundaries and a one-level stack
   assumes it watches the top's vector_call and pc_pop on clk */
`timescale 1ns/100ps
module sirq_core_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // from the top
  input wire logic vector_call,
  input wire logic pc_pop,
  // to the top
  output logic instr_boundary,
  output logic stack_full
);
  logic [1:0] phase_reg;
  logic depth_reg;
  // boundary once every four clocks
  assign instr_boundary = (phase_reg == 2'h3);
  assign stack_full = depth_reg;
  // phase and stack depth; a single level makes nesting visible
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_reg <= 2'h0;
      depth_reg <= 1'h0;
    end else begin
      phase_reg <= phase_reg + 2'h1;
      if (vector_call) depth_reg <= 1'h1;
      else if (pc_pop) depth_reg <= 1'h0;
    end
  end
endmodule

// ==== tb/tb_sirq_top.sv ====
/* bench for the serial irq top: events, entry and returns, wake
   assumes the core model and the bound checker are compiled first */
`timescale 1ns/100ps
module tb_sirq_top;
  // stimulus, driven on falling edges
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] mode = 2'h0;
  logic [8:0] ev = 9'h000;
  logic sw_flag_set = 1'b0, sw_flag_clr = 1'b0, sw_gie_set = 1'b0, sw_gie_clr = 1'b0;
  logic serial_module_irq_en = 1'b0, return_from_interrupt = 1'b0, plain_return = 1'b0;
  logic low_power = 1'b0, other_req_flags = 1'b0;
  wire logic byte_done, i2c_addr_match, i2c_bus_timeout, uart_tx_empty, uart_tx_idle;
  wire logic uart_rx_avail, uart_rx_overrun, uart_addr_det, uart_rx_wake;
  logic instr_boundary, stack_full, serial_module_req_flag, global_irq_en, in_service;
  logic vector_call, core_busy, pc_pop, wake_up;
  logic [1:0] src_mode;
  logic [11:0] vector_addr;
  int mismatches = 0, check_count = 0, cycles = 0, calls = 0;
  // event pulses, one bit each
  assign {uart_rx_wake, uart_addr_det, uart_rx_overrun, uart_rx_avail, uart_tx_idle,
    uart_tx_empty, i2c_bus_timeout, i2c_addr_match, byte_done} = ev;
  sirq_top dut (.*);
  sirq_core_model u_core (.*);
  // 25 ns clock
  always #12.5 clk = ~clk;
  // hang guard and vector call count
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (vector_call === 1'b1) calls <= calls + 1;
    if (cycles == 3000) begin
      mismatches = mismatches + 1;
      stop_test();
    end
  end
  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task chk(input string name, input logic [11:0] seen, input logic [11:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // bounded wait, a lost pulse shows as a long count
  task wait_sig(input bit sel_pop, output int n);
    n = 0;
    while ((sel_pop ? pc_pop : vector_call) !== 1'b1 && n < 40) begin
      cyc(1);
      n++;
    end
  endtask
  task t_events;
    logic exp;
    for (int m = 0; m < 4; m++) begin
      for (int e = 0; e < 9; e++) begin
        mode = 2'(m);
        ev = 9'h001 << e;
        cyc(1);
        ev = 9'h000;
        exp = (e < 3) ? (m < 2) : (m == 2);
        chk("flag set", 12'(serial_module_req_flag), 12'(exp));
        sw_flag_clr = 1'b1;
        cyc(1);
        sw_flag_clr = 1'b0;
      end
    end
    $display("events test done");
  endtask
  task t_entry;
    int n;
    serial_module_irq_en = 1'b1;
    mode = 2'h2;
    sw_gie_set = 1'b1;
    sw_flag_set = 1'b1;
    cyc(1);
    sw_gie_set = 1'b0;
    sw_flag_set = 1'b0;
    wait_sig(1'b0, n);
    chk("entry", {global_irq_en, serial_module_req_flag, vector_addr[9:0]}, 12'h010);
    chk("in service", 12'(in_service), 12'h001);
    chk("source mode", 12'(src_mode), 12'h002);
    sw_gie_set = 1'b1;
    sw_flag_set = 1'b1;
    cyc(1);
    sw_gie_set = 1'b0;
    sw_flag_set = 1'b0;
    cyc(20);
    chk("stack full calls", 12'(calls), 12'h001);
    return_from_interrupt = 1'b1;
    cyc(1);
    return_from_interrupt = 1'b0;
    wait_sig(1'b1, n);
    // one clock already spent holding the strobe, so eight remain
    chk("return_from_interrupt length", 12'(n), 12'h008);
    chk("return_from_interrupt enable", 12'(global_irq_en), 12'h001);
    cyc(14);
    chk("pending calls", 12'(calls), 12'h002);
    plain_return = 1'b1;
    cyc(1);
    plain_return = 1'b0;
    wait_sig(1'b1, n);
    chk("ret enable", 12'(global_irq_en), 12'h000);
    chk("ret length", 12'(n), 12'h008);
    chk("ret in service", 12'(in_service), 12'h000);
    $display("entry test done");
  endtask
  task t_wake;
    serial_module_irq_en = 1'b0;
    mode = 2'h0;
    low_power = 1'b1;
    other_req_flags = 1'b1;
    // wake pulse stands one cycle only
    cyc(1);
    chk("wake other", 12'(wake_up), 12'h001);
    low_power = 1'b0;
    sw_flag_set = 1'b1;
    cyc(1);
    sw_flag_set = 1'b0;
    cyc(1);
    low_power = 1'b1;
    ev = 9'h001;
    cyc(1);
    ev = 9'h000;
    cyc(2);
    chk("wake preset flag", 12'(wake_up), 12'h000);
    sw_flag_clr = 1'b1;
    cyc(1);
    sw_flag_clr = 1'b0;
    ev = 9'h001;
    cyc(1);
    ev = 9'h000;
    cyc(1);
    chk("wake serial", 12'(wake_up), 12'h001);
    $display("wake test done");
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // reset for five cycles, then the tests in turn
  initial begin
    cyc(5);
    rst_n = 1'b1;
    chk("reset", {global_irq_en, serial_module_req_flag, vector_addr[9:0]}, 12'h010);
    t_events();
    t_entry();
    t_wake();
    stop_test();
  end
endmodule
